//--- rtl/ssu_pkg.sv
// package of the serial sound unit: register map, field positions, sizes
// assumes a 32-bit register port with byte offsets on an 8-bit address
package ssu_pkg;

  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int          DATA_W     = 32;
  localparam int          FIFO_DEPTH = 32;
  localparam int          ADDR_W     = 8;
  localparam int          THR_W      = 5;
  localparam int          ERR_W      = 4;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0]  OFS_SOUND_CONTROL      = 8'h00;
  localparam logic [7:0]  OFS_SOUND_STATUS       = 8'h04;
  localparam logic [7:0]  OFS_FIFO_CONTROL       = 8'h10;
  localparam logic [7:0]  OFS_FIFO_STATUS        = 8'h14;
  localparam logic [7:0]  OFS_TRANSMIT_FIFO_DATA = 8'h18;
  localparam logic [7:0]  OFS_RECEIVE_FIFO_DATA  = 8'h1c;
  localparam logic [7:0]  OFS_OUTPUT_MODE        = 8'h20;
  localparam logic [7:0]  OFS_FIFO_THRESHOLD     = 8'h24;

  // ----------------------------------------
  // sound_control fields, error enables at ERR_LSB+3..ERR_LSB
  // ----------------------------------------
  localparam int          ERR_LSB    = 26;
  localparam int          CTL_MUTE   = 3;
  localparam int          CTL_TX_EN  = 1;
  localparam int          CTL_RX_EN  = 0;
  localparam logic [31:0] CTL_WMASK  = 32'h7fff_fffb;
  localparam logic [31:0] CTL_RESET  = 32'h0000_0000;

  // ----------------------------------------
  // sound_status fields, error flags share ERR_LSB
  // ----------------------------------------
  localparam int          STS_IDLE   = 25;

  // ----------------------------------------
  // fifo_control fields
  // ----------------------------------------
  localparam int          FCR_TX_IE  = 3;
  localparam int          FCR_RX_IE  = 2;
  localparam int          FCR_TX_RST = 1;
  localparam int          FCR_RX_RST = 0;
  localparam logic [31:0] FCR_WMASK  = 32'h8001_080f;
  localparam logic [31:0] FCR_RESET  = 32'h0000_0000;

  // ----------------------------------------
  // fifo_status fields
  // ----------------------------------------
  localparam int          FSR_RX_FULL    = 0;
  localparam int          FSR_RX_CNT_LSB = 8;
  localparam int          FSR_TX_EMPTY   = 16;
  localparam int          FSR_TX_CNT_LSB = 24;

  // ----------------------------------------
  // output_mode and fifo_threshold
  // ----------------------------------------
  localparam logic [31:0] OFR_WMASK      = 32'h0000_0303;
  localparam logic [31:0] OFR_RESET      = 32'h0000_0000;
  localparam int          SCR_RX_THR_LSB = 0;
  localparam int          SCR_TX_THR_LSB = 8;
  localparam logic [31:0] SCR_WMASK      = 32'h0000_1f1f;
  localparam logic [31:0] SCR_RESET      = 32'h0000_0000;

endpackage

//--- rtl/ssu_pin_sync.sv
// pin synchroniser with edge pulses for the serial sound link
// assumes inputs asynchronous to clk_in; three flops, change taken when
// the second and third agree
`timescale 1ns/1ps
module ssu_pin_sync #(
  parameter int           W    = 3,
  parameter logic [W-1:0] IDLE = '0
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  // pins
  input  wire logic [W-1:0] pin_in,
  // synchronised level and edges
  output logic      [W-1:0] level_out,
  output logic      [W-1:0] rise_out,
  output logic      [W-1:0] fall_out
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  logic [W-1:0] next_level;

  // ----------------------------------------
  // filter
  // ----------------------------------------
  always_comb begin
    next_level = level_out;
    for (int i = 0; i < W; i++) begin
      if (stage2[i] == stage3[i]) begin
        next_level[i] = stage2[i];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      stage1    <= IDLE;
      stage2    <= IDLE;
      stage3    <= IDLE;
      level_out <= IDLE;
      rise_out  <= '0;
      fall_out  <= '0;
    end else begin
      stage1    <= pin_in;
      stage2    <= stage1;
      stage3    <= stage2;
      level_out <= next_level;
      rise_out  <= next_level & ~level_out;
      fall_out  <= ~next_level & level_out;
    end
  end

endmodule

//--- rtl/ssu_top.sv
// serial sound unit: register file, 32-word fifos, i2s-style link, error irq
// assumes one 100 MHz clock, link pins from a codec that drives bit clock
// and word select; register port answers reads in the next cycle
`timescale 1ns/1ps
module ssu_top #(
  parameter int DATA_W = ssu_pkg::DATA_W,
  parameter int DEPTH  = ssu_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                      clk_in,
  input  wire logic                      rst_n_in,
  // register port
  input  wire logic [ssu_pkg::ADDR_W-1:0] reg_addr_in,
  input  wire logic [31:0]               reg_wdata_in,
  input  wire logic                      reg_wr_in,
  input  wire logic                      reg_rd_in,
  output logic      [31:0]               reg_rdata_out,
  // serial link
  input  wire logic                      link_bit_clk_in,
  input  wire logic                      link_word_sel_in,
  input  wire logic                      link_rx_data_in,
  output logic                           link_tx_data_out,
  // interrupt
  output logic                           irq_out
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = PTR_W + 1;
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function automatic logic hit(input logic [ssu_pkg::ADDR_W-1:0] a,
                               input logic [7:0]                 o);
    return a == o;
  endfunction

  // ----------------------------------------
  // link pins
  // ----------------------------------------
  logic [2:0] pin_level;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;

  ssu_pin_sync #(
    .W    (3),
    .IDLE (3'h1)
  ) u_sync (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .pin_in    ({link_rx_data_in, link_word_sel_in, link_bit_clk_in}),
    .level_out (pin_level),
    .rise_out  (pin_rise),
    .fall_out  (pin_fall)
  );

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [31:0]             ctrl;
  logic [31:0]             fcr;
  logic [31:0]             ofr;
  logic [31:0]             scr;
  logic [ssu_pkg::ERR_W-1:0] err;
  logic                    rx_full;
  logic                    tx_empty;
  logic [PTR_W-1:0]        tx_wptr;
  logic [PTR_W-1:0]        tx_rptr;
  logic [CNT_W-1:0]        tx_cnt;
  logic [PTR_W-1:0]        rx_wptr;
  logic [PTR_W-1:0]        rx_rptr;
  logic [CNT_W-1:0]        rx_cnt;
  logic                    ws_prev;
  logic                    rx_armed;
  logic [DATA_W-1:0]       rx_shift;
  logic [DATA_W-1:0]       tx_shift;
  logic [DATA_W-1:0]       tx_mem [DEPTH];
  logic [DATA_W-1:0]       rx_mem [DEPTH];

  logic [31:0]             next_ctrl;
  logic [31:0]             next_fcr;
  logic [31:0]             next_ofr;
  logic [31:0]             next_scr;
  logic [ssu_pkg::ERR_W-1:0] next_err;
  logic                    next_rx_full;
  logic                    next_tx_empty;
  logic [PTR_W-1:0]        next_tx_wptr;
  logic [PTR_W-1:0]        next_tx_rptr;
  logic [CNT_W-1:0]        next_tx_cnt;
  logic [PTR_W-1:0]        next_rx_wptr;
  logic [PTR_W-1:0]        next_rx_rptr;
  logic [CNT_W-1:0]        next_rx_cnt;
  logic                    next_ws_prev;
  logic                    next_rx_armed;
  logic [DATA_W-1:0]       next_rx_shift;
  logic [DATA_W-1:0]       next_tx_shift;
  logic                    next_tx_data;
  logic [31:0]             next_rdata;
  logic                    next_irq;

  logic                    tx_push;
  logic                    tx_pop;
  logic                    rx_push;
  logic                    rx_pop;
  logic [DATA_W-1:0]       rx_word;
  logic [ssu_pkg::ERR_W-1:0] err_set;
  logic [ssu_pkg::ERR_W-1:0] err_clr;
  logic                    boundary;
  logic [31:0]             rd_word;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_ctrl     = ctrl;
    next_fcr      = fcr;
    next_ofr      = ofr;
    next_scr      = scr;
    next_tx_wptr  = tx_wptr;
    next_tx_rptr  = tx_rptr;
    next_rx_wptr  = rx_wptr;
    next_rx_rptr  = rx_rptr;
    next_ws_prev  = ws_prev;
    next_rx_armed = rx_armed;
    next_rx_shift = rx_shift;
    next_tx_shift = tx_shift;
    next_tx_data  = link_tx_data_out;
    rd_word       = '0;

    // register writes
    if (reg_wr_in && hit(reg_addr_in, ssu_pkg::OFS_SOUND_CONTROL)) begin
      next_ctrl = reg_wdata_in & ssu_pkg::CTL_WMASK;
    end
    if (reg_wr_in && hit(reg_addr_in, ssu_pkg::OFS_FIFO_CONTROL)) begin
      next_fcr = reg_wdata_in & ssu_pkg::FCR_WMASK;
    end
    if (reg_wr_in && hit(reg_addr_in, ssu_pkg::OFS_OUTPUT_MODE)) begin
      next_ofr = reg_wdata_in & ssu_pkg::OFR_WMASK;
    end
    if (reg_wr_in && hit(reg_addr_in, ssu_pkg::OFS_FIFO_THRESHOLD)) begin
      next_scr = reg_wdata_in & ssu_pkg::SCR_WMASK;
    end

    // word boundary: word select changed at a bit clock rise
    boundary = pin_rise[0] && (pin_level[1] != ws_prev);
    rx_word  = {rx_shift[DATA_W-2:0], pin_level[2]};

    // transmit fifo, overflow drops the word
    tx_push = reg_wr_in && hit(reg_addr_in, ssu_pkg::OFS_TRANSMIT_FIFO_DATA)
              && (tx_cnt != FULL_CNT) && !fcr[ssu_pkg::FCR_TX_RST];
    tx_pop  = boundary && ctrl[ssu_pkg::CTL_TX_EN] && (tx_cnt != '0);

    // receive fifo, overflow drops the word, underflow reads zero
    rx_push = boundary && ctrl[ssu_pkg::CTL_RX_EN] && rx_armed
              && (rx_cnt != FULL_CNT) && !fcr[ssu_pkg::FCR_RX_RST];
    rx_pop  = reg_rd_in && hit(reg_addr_in, ssu_pkg::OFS_RECEIVE_FIFO_DATA)
              && (rx_cnt != '0);

    // error events {tx underflow, tx overflow, rx underflow, rx overflow}
    err_set[3] = boundary && ctrl[ssu_pkg::CTL_TX_EN] && (tx_cnt == '0);
    err_set[2] = reg_wr_in && hit(reg_addr_in, ssu_pkg::OFS_TRANSMIT_FIFO_DATA)
                 && (tx_cnt == FULL_CNT);
    err_set[1] = reg_rd_in && hit(reg_addr_in, ssu_pkg::OFS_RECEIVE_FIFO_DATA)
                 && (rx_cnt == '0);
    err_set[0] = boundary && ctrl[ssu_pkg::CTL_RX_EN] && rx_armed
                 && (rx_cnt == FULL_CNT);
    err_clr    = '0;
    if (reg_wr_in && hit(reg_addr_in, ssu_pkg::OFS_SOUND_STATUS)) begin
      err_clr = reg_wdata_in[ssu_pkg::ERR_LSB +: ssu_pkg::ERR_W];
    end
    next_err = (err & ~err_clr) | err_set;

    // fifo pointers and counts
    if (tx_push) begin
      next_tx_wptr = tx_wptr + PTR_W'(1);
    end
    if (tx_pop) begin
      next_tx_rptr = tx_rptr + PTR_W'(1);
    end
    next_tx_cnt = tx_cnt + CNT_W'(tx_push) - CNT_W'(tx_pop);
    if (fcr[ssu_pkg::FCR_TX_RST]) begin
      next_tx_wptr = '0;
      next_tx_rptr = '0;
      next_tx_cnt  = '0;
    end
    if (rx_push) begin
      next_rx_wptr = rx_wptr + PTR_W'(1);
    end
    if (rx_pop) begin
      next_rx_rptr = rx_rptr + PTR_W'(1);
    end
    next_rx_cnt = rx_cnt + CNT_W'(rx_push) - CNT_W'(rx_pop);
    if (fcr[ssu_pkg::FCR_RX_RST]) begin
      next_rx_wptr = '0;
      next_rx_rptr = '0;
      next_rx_cnt  = '0;
    end

    // rx full: set on a push reaching threshold plus one, set beats clear
    next_rx_full = rx_full;
    if (reg_wr_in && hit(reg_addr_in, ssu_pkg::OFS_FIFO_STATUS)
        && reg_wdata_in[ssu_pkg::FSR_RX_FULL]) begin
      next_rx_full = 1'b0;
    end
    if (rx_push && (rx_cnt >= CNT_W'(scr[ssu_pkg::SCR_RX_THR_LSB +: ssu_pkg::THR_W]))) begin
      next_rx_full = 1'b1;
    end

    // tx empty: set while free space reaches threshold plus one
    next_tx_empty = tx_empty;
    if (reg_wr_in && hit(reg_addr_in, ssu_pkg::OFS_FIFO_STATUS)
        && reg_wdata_in[ssu_pkg::FSR_TX_EMPTY]) begin
      next_tx_empty = 1'b0;
    end
    if ((FULL_CNT - tx_cnt) > CNT_W'(scr[ssu_pkg::SCR_TX_THR_LSB +: ssu_pkg::THR_W])) begin
      next_tx_empty = 1'b1;
    end

    // link: receive on bit clock rise, transmit on fall
    if (pin_rise[0]) begin
      next_ws_prev  = pin_level[1];
      next_rx_shift = rx_word;
    end
    if (boundary) begin
      next_rx_armed = ctrl[ssu_pkg::CTL_RX_EN];
      next_tx_shift = tx_pop ? tx_mem[tx_rptr] : '0;
    end
    if (!ctrl[ssu_pkg::CTL_RX_EN]) begin
      next_rx_armed = 1'b0;
    end
    if (pin_fall[0]) begin
      next_tx_data  = tx_shift[DATA_W-1] && ctrl[ssu_pkg::CTL_TX_EN]
                      && !ctrl[ssu_pkg::CTL_MUTE];
      next_tx_shift = {tx_shift[DATA_W-2:0], 1'b0};
    end

    // register reads, data only in the cycle after the strobe
    case (reg_addr_in)
      ssu_pkg::OFS_SOUND_CONTROL: begin
        rd_word = ctrl;
      end
      ssu_pkg::OFS_SOUND_STATUS: begin
        rd_word[ssu_pkg::ERR_LSB +: ssu_pkg::ERR_W] = err;
        rd_word[ssu_pkg::STS_IDLE] = !(ctrl[ssu_pkg::CTL_TX_EN] || ctrl[ssu_pkg::CTL_RX_EN]);
      end
      ssu_pkg::OFS_FIFO_CONTROL: begin
        rd_word = fcr;
      end
      ssu_pkg::OFS_FIFO_STATUS: begin
        rd_word[ssu_pkg::FSR_RX_FULL] = rx_full;
        rd_word[ssu_pkg::FSR_RX_CNT_LSB +: CNT_W] = rx_cnt;
        rd_word[ssu_pkg::FSR_TX_EMPTY] = tx_empty;
        rd_word[ssu_pkg::FSR_TX_CNT_LSB +: CNT_W] = tx_cnt;
      end
      ssu_pkg::OFS_RECEIVE_FIFO_DATA: begin
        rd_word = (rx_cnt != '0) ? 32'(rx_mem[rx_rptr]) : '0;
      end
      ssu_pkg::OFS_OUTPUT_MODE: begin
        rd_word = ofr;
      end
      ssu_pkg::OFS_FIFO_THRESHOLD: begin
        rd_word = scr;
      end
      default: begin
        rd_word = '0;
      end
    endcase
    next_rdata = reg_rd_in ? rd_word : '0;

    // each error reaches the irq only through its own enable
    next_irq = (next_err[3] && next_ctrl[ssu_pkg::ERR_LSB + 3])
            || (next_err[2] && next_ctrl[ssu_pkg::ERR_LSB + 2])
            || (next_err[1] && next_ctrl[ssu_pkg::ERR_LSB + 1])
            || (next_err[0] && next_ctrl[ssu_pkg::ERR_LSB])
            || (next_rx_full && next_fcr[ssu_pkg::FCR_RX_IE])
            || (next_tx_empty && next_fcr[ssu_pkg::FCR_TX_IE]);
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ctrl             <= ssu_pkg::CTL_RESET;
      fcr              <= ssu_pkg::FCR_RESET;
      ofr              <= ssu_pkg::OFR_RESET;
      scr              <= ssu_pkg::SCR_RESET;
      err              <= '0;
      rx_full          <= 1'b0;
      tx_empty         <= 1'b0;
      tx_wptr          <= '0;
      tx_rptr          <= '0;
      tx_cnt           <= '0;
      rx_wptr          <= '0;
      rx_rptr          <= '0;
      rx_cnt           <= '0;
      ws_prev          <= 1'b0;
      rx_armed         <= 1'b0;
      rx_shift         <= '0;
      tx_shift         <= '0;
      link_tx_data_out <= 1'b0;
      reg_rdata_out    <= '0;
      irq_out          <= 1'b0;
    end else begin
      ctrl             <= next_ctrl;
      fcr              <= next_fcr;
      ofr              <= next_ofr;
      scr              <= next_scr;
      err              <= next_err;
      rx_full          <= next_rx_full;
      tx_empty         <= next_tx_empty;
      tx_wptr          <= next_tx_wptr;
      tx_rptr          <= next_tx_rptr;
      tx_cnt           <= next_tx_cnt;
      rx_wptr          <= next_rx_wptr;
      rx_rptr          <= next_rx_rptr;
      rx_cnt           <= next_rx_cnt;
      ws_prev          <= next_ws_prev;
      rx_armed         <= next_rx_armed;
      rx_shift         <= next_rx_shift;
      tx_shift         <= next_tx_shift;
      link_tx_data_out <= next_tx_data;
      reg_rdata_out    <= next_rdata;
      irq_out          <= next_irq;
    end
  end

  // ----------------------------------------
  // fifo storage
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (tx_push) begin
      tx_mem[tx_wptr] <= reg_wdata_in[DATA_W-1:0];
    end
    if (rx_push) begin
      rx_mem[rx_wptr] <= rx_word;
    end
  end

endmodule

//--- dv/ssu_codec_model.sv
// behavioural codec at the far end of the serial sound link
// assumes the block samples these pins with its own clock
`timescale 1ns/1ps
module ssu_codec_model (
  // control from the bench
  input  wire logic        run_in,
  input  wire logic [31:0] word_in,
  // link pins
  output logic             bit_clk_out,
  output logic             word_sel_out,
  output logic             data_out
);
  // ----------------------------------------
  // word generator
  // ----------------------------------------
  // msb first, word select moves with the lsb; bit clock stands still between runs
  initial begin
    bit_clk_out  = 1'b1;
    word_sel_out = 1'b0;
    data_out     = 1'b0;
    forever begin
      if (run_in !== 1'b1) begin
        data_out = ~data_out;
        wait (run_in === 1'b1);
        #3;
      end
      for (int b = 31; b >= 0; b--) begin
        #80;
        bit_clk_out = 1'b0;
        data_out    = word_in[b];
        if (b == 0) begin
          word_sel_out = ~word_sel_out;
        end
        #80;
        bit_clk_out = 1'b1;
      end
    end
  end
endmodule

//--- dv/ssu_top_assertions.sv
// checker of the serial sound unit register port and interrupt
// assumes it is bound to ssu_top and sees only its ports
`timescale 1ns/1ps
module ssu_top_assertions #(
  parameter int DATA_W = 32,
  parameter int DEPTH  = 32
) (
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic        link_bit_clk_in,
  input wire logic        link_word_sel_in,
  input wire logic        link_rx_data_in,
  input wire logic        link_tx_data_out,
  input wire logic        irq_out
);
  // ----------------------------------------
  // mirrors of written control bits
  // ----------------------------------------
  logic [31:0] ctl;
  logic [31:0] next_ctl;
  logic [3:0]  fcr;
  logic [3:0]  next_fcr;
  logic        rd_fsr;
  logic        next_rd_fsr;
  logic        rxf_seen;
  logic        next_rxf_seen;
  logic        wr_ctl;
  logic        wr_fcr;
  logic        wr_fsr;

  always_comb begin
    wr_ctl        = reg_wr_in && reg_addr_in == ssu_pkg::OFS_SOUND_CONTROL;
    wr_fcr        = reg_wr_in && reg_addr_in == ssu_pkg::OFS_FIFO_CONTROL;
    wr_fsr        = reg_wr_in && reg_addr_in == ssu_pkg::OFS_FIFO_STATUS;
    next_ctl      = wr_ctl ? (reg_wdata_in & ssu_pkg::CTL_WMASK) : ctl;
    next_fcr      = wr_fcr ? reg_wdata_in[3:0] : fcr;
    next_rd_fsr   = reg_rd_in && reg_addr_in == ssu_pkg::OFS_FIFO_STATUS;
    next_rxf_seen = rxf_seen;
    if (rd_fsr && reg_rdata_out[0]) begin
      next_rxf_seen = 1'b1;
    end
    if (wr_fsr || wr_fcr) begin
      next_rxf_seen = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ctl      <= 32'h0000_0000;
      fcr      <= 4'h0;
      rd_fsr   <= 1'b0;
      rxf_seen <= 1'b0;
    end else begin
      ctl      <= next_ctl;
      fcr      <= next_fcr;
      rd_fsr   <= next_rd_fsr;
      rxf_seen <= next_rxf_seen;
    end
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence rd_of(logic [7:0] a);
    reg_rd_in && reg_addr_in == a ##1 1'b1;
  endsequence

  property err_irq(int b);
    rd_of(ssu_pkg::OFS_SOUND_STATUS) ##0 (reg_rdata_out[b] && ctl[b]) |-> irq_out;
  endproperty

  tx_under_irq_a: assert property (err_irq(ssu_pkg::ERR_LSB + 3))
    else $error("tx underflow flag enabled but irq low");
  tx_over_irq_a: assert property (err_irq(ssu_pkg::ERR_LSB + 2))
    else $error("tx overflow flag enabled but irq low");
  rx_under_irq_a: assert property (err_irq(ssu_pkg::ERR_LSB + 1))
    else $error("rx underflow flag enabled but irq low");
  rx_over_irq_a: assert property (err_irq(ssu_pkg::ERR_LSB))
    else $error("rx overflow flag enabled but irq low");
  masked_quiet_a: assert property (ctl[29:26] == 4'h0 && fcr[3:2] == 2'h0 |-> !irq_out)
    else $error("irq high with every enable off");
  irq_sticky_a: assert property (irq_out && !reg_wr_in |=> irq_out)
    else $error("irq dropped without a register write");
  count_range_a: assert property (rd_of(ssu_pkg::OFS_FIFO_STATUS)
    |-> reg_rdata_out[13:8] <= DEPTH && reg_rdata_out[29:24] <= DEPTH)
    else $error("fifo count above depth");
  rx_full_hold_a: assert property (rd_of(ssu_pkg::OFS_FIFO_STATUS) ##0 rxf_seen
    |-> reg_rdata_out[0])
    else $error("rx full cleared without a write");
  rdata_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0000_0000)
    else $error("read data outside the answer cycle");
  ctl_readback_a: assert property (rd_of(ssu_pkg::OFS_SOUND_CONTROL) |-> reg_rdata_out == ctl)
    else $error("control readback differs from written bits");
endmodule

bind ssu_top ssu_top_assertions #(.DATA_W(DATA_W), .DEPTH(DEPTH)) ssu_top_assertions_inst (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .link_bit_clk_in(link_bit_clk_in),
  .link_word_sel_in(link_word_sel_in), .link_rx_data_in(link_rx_data_in),
  .link_tx_data_out(link_tx_data_out), .irq_out(irq_out)
);

//--- dv/tb_ssu_top.sv
// testbench of the serial sound unit: registers, error flags, irq, link
// assumes the codec model drives the link pins
`timescale 1ns/1ps
module tb_ssu_top;
  localparam logic [7:0]  CTL     = ssu_pkg::OFS_SOUND_CONTROL;
  localparam logic [7:0]  STS     = ssu_pkg::OFS_SOUND_STATUS;
  localparam logic [7:0]  FCR     = ssu_pkg::OFS_FIFO_CONTROL;
  localparam logic [7:0]  FSR     = ssu_pkg::OFS_FIFO_STATUS;
  localparam logic [7:0]  TXD     = ssu_pkg::OFS_TRANSMIT_FIFO_DATA;
  localparam logic [7:0]  RXD     = ssu_pkg::OFS_RECEIVE_FIFO_DATA;
  localparam logic [7:0]  SCR     = ssu_pkg::OFS_FIFO_THRESHOLD;
  localparam logic [7:0]  RW_OFS [4] = '{CTL, FCR, ssu_pkg::OFS_OUTPUT_MODE, SCR};
  localparam logic [31:0] RW_MSK [4] = '{ssu_pkg::CTL_WMASK, ssu_pkg::FCR_WMASK,
                                         ssu_pkg::OFR_WMASK, ssu_pkg::SCR_WMASK};
  localparam logic [31:0] RX_WORD = 32'hc3a5_9617;

  logic        clk_in;
  logic        rst_n_in;
  logic [7:0]  reg_addr_in;
  logic [31:0] reg_wdata_in;
  logic        reg_wr_in;
  logic        reg_rd_in;
  logic [31:0] reg_rdata_out;
  logic        link_bit_clk_in;
  logic        link_word_sel_in;
  logic        link_rx_data_in;
  logic        link_tx_data_out;
  logic        irq_out;
  logic        run;
  logic [31:0] d;
  logic        tx_seen = 1'b0;
  int          mismatches;
  int          n_tests;

  ssu_top ssu_top_inst (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .link_bit_clk_in(link_bit_clk_in),
    .link_word_sel_in(link_word_sel_in), .link_rx_data_in(link_rx_data_in),
    .link_tx_data_out(link_tx_data_out), .irq_out(irq_out)
  );

  ssu_codec_model ssu_codec_model_inst (
    .run_in(run), .word_in(RX_WORD), .bit_clk_out(link_bit_clk_in),
    .word_sel_out(link_word_sel_in), .data_out(link_rx_data_in)
  );

  // ----------------------------------------
  // clock and shared tasks
  // ----------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    if (link_tx_data_out === 1'b1) tx_seen <= 1'b1;
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_in);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= v;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_in);
    reg_rd_in   <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1;
    v = reg_rdata_out;
  endtask

  task automatic irq_is(input logic e);
    #1;
    chk("irq_out", 32'(irq_out), 32'(e));
  endtask

  task automatic wait_bit(input logic [7:0] a, input int b);
    int          k;
    logic [31:0] v;
    for (k = 0; k < 20000; k++) begin
      rd(a, v);
      if (v[b] === 1'b1) break;
    end
    if (k == 20000) begin
      mismatches++;
      $display("unexpected timeout on register %h", a);
      finish_test();
    end
  endtask

  // halt the link, then walk one error flag through mask, stickiness and clear
  task automatic check_err(input int b);
    logic [31:0] v;
    @(posedge clk_in);
    run <= 1'b0;
    wr(CTL, 32'h0000_0000);
    irq_is(1'b0);
    wr(CTL, 32'h0000_0001 << b);
    irq_is(1'b1);
    rd(STS, v);
    chk("error flag", 32'(v[b]), 32'h1);
    wr(CTL, 32'h0000_0000);
    irq_is(1'b0);
    rd(STS, v);
    chk("flag kept", 32'(v[b]), 32'h1);
    wr(STS, 32'h0000_0001 << b);
    wr(CTL, 32'h0000_0001 << b);
    irq_is(1'b0);
    wr(CTL, 32'h0000_0000);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_n_in     = 1'b0;
    reg_addr_in  = 8'h00;
    reg_wdata_in = 32'h0000_0000;
    reg_wr_in    = 1'b0;
    reg_rd_in    = 1'b0;
    run          = 1'b0;
    mismatches   = 0;
    n_tests      = 0;
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(RW_OFS[i], d);
      chk("reset value", d, 32'h0000_0000);
      wr(RW_OFS[i], 32'hffff_ffff);
      rd(RW_OFS[i], d);
      chk("written bits", d, RW_MSK[i]);
      wr(RW_OFS[i], 32'h0000_0000);
    end
    rd(STS, d);
    chk("status idle", d, 32'h0000_0001 << ssu_pkg::STS_IDLE);
    wr(8'h08, 32'hffff_ffff);
    rd(8'h08, d);
    chk("unmapped read", d, 32'h0000_0000);
    // tx overflow: fill with tx off, one word too many
    for (int i = 0; i < 32; i++) begin
      wr(TXD, 32'(i));
    end
    rd(FSR, d);
    chk("tx count full", 32'(d[29:24]), 32'h0000_0020);
    wr(TXD, 32'hffff_ffff);
    rd(FSR, d);
    chk("tx count kept", 32'(d[29:24]), 32'h0000_0020);
    check_err(ssu_pkg::ERR_LSB + 2);
    wr(FCR, 32'h0000_0002);
    wr(FCR, 32'h0000_0000);
    rd(FSR, d);
    chk("tx count empty", 32'(d[29:24]), 32'h0000_0000);
    // rx underflow: read of an empty fifo
    rd(RXD, d);
    chk("empty rx read", d, 32'h0000_0000);
    check_err(ssu_pkg::ERR_LSB + 1);
    // rx path: threshold 1, then fill past full
    wr(SCR, 32'h0000_0001);
    wr(CTL, 32'h0c00_0001);
    @(posedge clk_in);
    run <= 1'b1;
    wait_bit(FSR, ssu_pkg::FSR_RX_FULL);
    rd(FSR, d);
    chk("rx count at full", 32'(d[13:8]), 32'h0000_0002);
    rd(RXD, d);
    chk("rx word", d, RX_WORD);
    rd(FSR, d);
    chk("rx full kept", 32'(d[0]), 32'h0000_0001);
    wr(FSR, 32'h0000_0001);
    rd(FSR, d);
    chk("rx full cleared", 32'(d[0]), 32'h0000_0000);
    wait_bit(STS, ssu_pkg::ERR_LSB);
    irq_is(1'b1);
    rd(FSR, d);
    chk("rx count full", 32'(d[13:8]), 32'h0000_0020);
    check_err(ssu_pkg::ERR_LSB);
    wr(FCR, 32'h0000_0001);
    wr(FCR, 32'h0000_0000);
    // tx underflow: send one word, then transmit from an empty fifo
    wr(TXD, 32'hffff_ffff);
    wr(CTL, 32'h3000_0002);
    @(posedge clk_in);
    run <= 1'b1;
    wait_bit(STS, ssu_pkg::ERR_LSB + 3);
    irq_is(1'b1);
    chk("tx data", 32'(tx_seen), 32'h0000_0001);
    check_err(ssu_pkg::ERR_LSB + 3);
    finish_test();
  end
endmodule
